// >>> rtl/drl_loader.sv
// Serial loader for the control, double-buffered reference and swallow-count
// registers of one synthesizer device in a cascaded chain.
// Assumes serial clock, data and chip enable arrive asynchronously on pins.
// Assumes each serial clock phase and the enable setup and hold last at least 4 mclk.
// Assumes ser_dout feeds the next device's ser_din in a chain.
// Assumes arst_n may fall at any time; it is released here through two flops.
`timescale 1ns/1ps
`default_nettype none

module drl_loader (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic ser_clk,
  input wire logic ser_din,
  input wire logic ser_enb_n,
  output logic ser_dout,
  output drl_pkg::drl_ratio_s ratio,
  output logic ratio_load,
  output logic [drl_pkg::REF_CFG_W-1:0] ref_cfg,
  output logic [drl_pkg::CTRL_W-1:0] ctrl_reg
);

  // ************************************************************
  // Reset release
  // ************************************************************
  logic [1:0] rst_sync_r;
  logic rst_n;

  // Two-stage release of the asynchronous reset
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_r[1];

  // ************************************************************
  // Loader state
  // ************************************************************
  drl_pkg::drl_state_s st_r;
  drl_pkg::drl_state_s st_nxt;
  logic sclk_rise;
  logic frame_end;
  logic enb_act;

  // ************************************************************
  // Edge detection
  // ************************************************************
  // Edge of the synchronised serial clock, enable level
  assign sclk_rise = st_r.sclk_sync[1] && !st_r.sclk_prev;
  assign enb_act = !st_r.enb_n_sync[1];
  // End of frame when enable rises
  assign frame_end = st_r.enb_n_sync[1] && !st_r.enb_n_prev;

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  logic [1:0] sclk_sync_in;
  logic [1:0] din_sync_in;
  logic [1:0] enb_n_sync_in;

  // Two flops per pin; only the second flop feeds logic
  assign sclk_sync_in = {st_r.sclk_sync[0], ser_clk};
  assign din_sync_in = {st_r.din_sync[0], ser_din};
  assign enb_n_sync_in = {st_r.enb_n_sync[0], ser_enb_n};

  // ************************************************************
  // Shift path and cascade output
  // ************************************************************
  logic shift_en;
  logic cnt_full;
  logic dout_in;
  logic [drl_pkg::SHIFT_W-1:0] shift_in;

  // One bit per rising serial clock under enable, MSB first
  assign shift_en = enb_act && sclk_rise;
  assign shift_in = {st_r.shift[drl_pkg::SHIFT_W-2:0], st_r.din_sync[1]};
  // Oldest bit leaves for the next device in the chain
  assign dout_in = st_r.shift[drl_pkg::SHIFT_W-1];
  // Overlong frames stop the count instead of wrapping onto a legal length
  assign cnt_full = (st_r.clk_cnt == drl_pkg::CLK_CNT_MAX);

  // ************************************************************
  // Own-device fields, always the last bits shifted in
  // ************************************************************
  logic [drl_pkg::CTRL_W-1:0] ctrl_field;
  logic [drl_pkg::REF_CFG_W-1:0] cfg_field;
  logic [drl_pkg::REF_RATIO_W-1:0] stage1_field;
  logic [drl_pkg::MAIN_W-1:0] main_field;
  logic [drl_pkg::SWL_W-1:0] swl_field;

  // Fixed slices of the shift register
  assign ctrl_field = st_r.shift[drl_pkg::CTRL_W-1:0];
  assign cfg_field = st_r.shift[drl_pkg::REF_CFG_LSB +: drl_pkg::REF_CFG_W];
  assign stage1_field = st_r.shift[drl_pkg::REF_LSB +: drl_pkg::REF_RATIO_W];
  assign main_field = st_r.shift[drl_pkg::MAIN_LSB +: drl_pkg::MAIN_W];
  assign swl_field = st_r.shift[drl_pkg::SWL_LSB +: drl_pkg::SWL_W];

  // ************************************************************
  // Frame length decode
  // ************************************************************
  logic len_ctrl;
  logic len_ref;
  logic len_swl;
  logic commit_ctrl;
  logic commit_ref;
  logic commit_swl;

  // Clock count under enable names the target; other lengths commit nothing
  assign len_ctrl = (st_r.clk_cnt == drl_pkg::CTRL_CLKS_ONE) || (st_r.clk_cnt == drl_pkg::CTRL_CLKS_TWO);
  assign len_ref = (st_r.clk_cnt == drl_pkg::REF_CLKS_ONE) || (st_r.clk_cnt == drl_pkg::REF_CLKS_TWO);
  assign len_swl = (st_r.clk_cnt == drl_pkg::SWL_CLKS_ONE) || (st_r.clk_cnt == drl_pkg::SWL_CLKS_TWO);

  // One-cycle commit strobes on release of enable
  assign commit_ctrl = frame_end && len_ctrl;
  assign commit_ref = frame_end && len_ref;
  assign commit_swl = frame_end && len_swl;

  // ************************************************************
  // Next state
  // ************************************************************
  // Synchronise, shift, count and commit
  always_comb begin
    st_nxt = st_r;
    // Pin history for the edge detectors
    st_nxt.sclk_sync = sclk_sync_in;
    st_nxt.din_sync = din_sync_in;
    st_nxt.enb_n_sync = enb_n_sync_in;
    st_nxt.sclk_prev = st_r.sclk_sync[1];
    st_nxt.enb_n_prev = st_r.enb_n_sync[1];
    // Load strobe lasts one cycle
    st_nxt.ratio_load = 1'b0;
    // Shift while enabled; the oldest bit goes on to the next device
    if (shift_en) begin
      st_nxt.shift = shift_in;
      st_nxt.dout = dout_in;
      if (!cnt_full) begin
        st_nxt.clk_cnt = st_r.clk_cnt + 6'h01;
      end
    end
    // Count restarts for the next frame
    if (frame_end) begin
      st_nxt.clk_cnt = 6'h00;
    end
    // Control frame: control register only
    if (commit_ctrl) begin
      st_nxt.ctrl = ctrl_field;
    end
    // Reference frame: first stage and configuration only; live ratios untouched
    if (commit_ref) begin
      st_nxt.ref_cfg = cfg_field;
      st_nxt.ref_stage1 = stage1_field;
    end
    // Swallow frame: bytes held, second stage loaded, all ratios at once
    if (commit_swl) begin
      st_nxt.swallow_reg = st_r.shift;
      st_nxt.ratio.ref_ratio = st_r.ref_stage1;
      st_nxt.ratio.main_ratio = main_field;
      st_nxt.ratio.swallow_ratio = swl_field;
      st_nxt.ratio_load = 1'b1;
    end
  end

  // ************************************************************
  // State register
  // ************************************************************
  // Every field registered each mclk; constants only under reset
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      // Pin history at idle levels, so no false edge follows reset
      st_r.sclk_sync <= 2'h0;
      st_r.sclk_prev <= 1'b0;
      st_r.din_sync <= 2'h0;
      st_r.enb_n_sync <= 2'h3;
      st_r.enb_n_prev <= 1'b1;
      st_r.shift <= 24'h000000;
      st_r.clk_cnt <= 6'h00;
      st_r.ctrl <= drl_pkg::CTRL_RST;
      st_r.ref_cfg <= drl_pkg::REF_CFG_RST;
      st_r.ref_stage1 <= drl_pkg::REF_RATIO_RST;
      st_r.swallow_reg <= 24'h000000;
      st_r.ratio.ref_ratio <= drl_pkg::REF_RATIO_RST;
      st_r.ratio.main_ratio <= drl_pkg::MAIN_RST;
      st_r.ratio.swallow_ratio <= drl_pkg::SWL_RST;
      st_r.ratio_load <= 1'b0;
      st_r.dout <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  // Every output straight from the state register
  assign ser_dout = st_r.dout;
  assign ratio = st_r.ratio;
  assign ratio_load = st_r.ratio_load;
  assign ref_cfg = st_r.ref_cfg;
  assign ctrl_reg = st_r.ctrl;

endmodule

`default_nettype wire

// >>> rtl/drl_pkg.sv
// Package for the divide-ratio serial loader: frame lengths, field layout,
// reset values and the state and output carriers.
// Assumes a single clock mclk and pins that are asynchronous to it.
package drl_pkg;

  // ************************************************************
  // Frame lengths, one device and two cascaded devices
  // ************************************************************
  localparam logic [5:0] CTRL_CLKS_ONE = 6'h10;
  localparam logic [5:0] CTRL_CLKS_TWO = 6'h20;
  localparam logic [5:0] REF_CLKS_ONE = 6'h14;
  localparam logic [5:0] REF_CLKS_TWO = 6'h28;
  localparam logic [5:0] SWL_CLKS_ONE = 6'h18;
  localparam logic [5:0] SWL_CLKS_TWO = 6'h30;
  localparam logic [5:0] CLK_CNT_MAX = 6'h3F;

  // ************************************************************
  // Field layout of the own-device bits in the shift register
  // ************************************************************
  localparam int SHIFT_W = 24;
  localparam int CTRL_W = 8;
  localparam int REF_LSB = 0;
  localparam int REF_RATIO_W = 13;
  localparam int REF_CFG_LSB = 13;
  localparam int REF_CFG_W = 3;
  localparam int SWL_LSB = 0;
  localparam int SWL_W = 6;
  localparam int MAIN_LSB = 6;
  localparam int MAIN_W = 12;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [CTRL_W-1:0] CTRL_RST = 8'h00;
  localparam logic [REF_RATIO_W-1:0] REF_RATIO_RST = 13'h0001;
  localparam logic [REF_CFG_W-1:0] REF_CFG_RST = 3'h0;
  localparam logic [SWL_W-1:0] SWL_RST = 6'h00;
  localparam logic [MAIN_W-1:0] MAIN_RST = 12'h028;

  // Ratios presented to the counters
  typedef struct packed {
    logic [REF_RATIO_W-1:0] ref_ratio;
    logic [MAIN_W-1:0] main_ratio;
    logic [SWL_W-1:0] swallow_ratio;
  } drl_ratio_s;

  // All state of the loader except the reset release flops
  typedef struct packed {
    logic [1:0] sclk_sync;
    logic sclk_prev;
    logic [1:0] din_sync;
    logic [1:0] enb_n_sync;
    logic enb_n_prev;
    logic [SHIFT_W-1:0] shift;
    logic [5:0] clk_cnt;
    logic [CTRL_W-1:0] ctrl;
    logic [REF_CFG_W-1:0] ref_cfg;
    logic [REF_RATIO_W-1:0] ref_stage1;
    logic [SHIFT_W-1:0] swallow_reg;
    drl_ratio_s ratio;
    logic ratio_load;
    logic dout;
  } drl_state_s;

endpackage

// >>> sim/drl_loader_tb.sv
// Self-checking bench for the divide-ratio loader.
// Assumes drl_master as the serial controller.
`timescale 1ns/1ps
`default_nettype none
module drl_loader_tb;
  logic mclk;
  logic arst_n;
  logic ser_clk, ser_din, ser_enb_n, ser_dout, ratio_load;
  drl_pkg::drl_ratio_s ratio;
  logic [2:0] ref_cfg;
  logic [7:0] ctrl_reg;
  int n_fail = 0;
  int n_checks = 0;
  int n_load = 0;
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  always @(posedge mclk) if (ratio_load === 1'b1) n_load <= n_load + 1;
  drl_master u_drl_master (.mclk, .ser_clk, .ser_din, .ser_enb_n);
  drl_loader u_drl_loader (.mclk, .arst_n, .ser_clk, .ser_din, .ser_enb_n, .ser_dout, .ratio, .ratio_load,
    .ref_cfg, .ctrl_reg);
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic regs(input logic [30:0] r, input logic [2:0] c, input logic [7:0] k);
    chk(64'(ratio), 64'(r));
    chk(64'(ref_cfg), 64'(c));
    chk(64'(ctrl_reg), 64'(k));
  endtask
  task automatic give_verdict;
    $display("checks %0d fails %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic t_ctrl;
    regs({13'h0001, 12'h028, 6'h00}, 3'h0, 8'h00);
    u_drl_master.frame(16, 48'h5A);
    regs({13'h0001, 12'h028, 6'h00}, 3'h0, 8'h5A);
    u_drl_master.frame(32, 48'hC3A5);
    regs({13'h0001, 12'h028, 6'h00}, 3'h0, 8'hA5);
  endtask
  task automatic t_ref_swl;
    u_drl_master.frame(40, {8'h00, 20'hFFFFF, 4'h0, 3'h5, 13'h1ABC});
    regs({13'h0001, 12'h028, 6'h00}, 3'h5, 8'hA5);
    chk(64'(ser_dout), 64'h1);
    u_drl_master.frame(48, {24'h123456, 6'h00, 12'hABC, 6'h2D});
    regs({13'h1ABC, 12'hABC, 6'h2D}, 3'h5, 8'hA5);
    chk(64'(ser_dout), 64'h0);
    chk(64'(n_load), 64'h1);
  endtask
  task automatic t_refuse_hold;
    u_drl_master.frame(20, {28'h0, 4'h0, 3'h2, 13'h0777});
    u_drl_master.frame(23, 48'h7FFFFF);
    regs({13'h1ABC, 12'hABC, 6'h2D}, 3'h2, 8'hA5);
    u_drl_master.frame(24, {24'h0, 6'h00, 12'h123, 6'h11});
    regs({13'h0777, 12'h123, 6'h11}, 3'h2, 8'hA5);
    u_drl_master.frame(24, {24'h0, 6'h3F, 12'h456, 6'h22});
    regs({13'h0777, 12'h456, 6'h22}, 3'h2, 8'hA5);
    chk(64'(n_load), 64'h3);
  endtask
  task automatic t_mid_reset;
    arst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    regs({13'h0001, 12'h028, 6'h00}, 3'h0, 8'h00);
    chk(64'(ser_dout), 64'h0);
    arst_n <= 1'b1;
    repeat (4) @(posedge mclk);
    u_drl_master.frame(16, 48'h3C);
    regs({13'h0001, 12'h028, 6'h00}, 3'h0, 8'h3C);
    chk(64'(n_load), 64'h3);
  endtask
  // Main sequence
  initial begin
    arst_n <= 1'b0;
    repeat (12) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (4) @(posedge mclk);
    t_ctrl();
    t_ref_swl();
    t_refuse_hold();
    t_mid_reset();
    give_verdict();
  end
  // Watchdog
  initial begin
    repeat (20000) @(posedge mclk);
    n_fail++;
    give_verdict();
  end
endmodule
`default_nettype wire

// >>> sim/drl_master.sv
// Serial controller model driving the loader pins.
// Assumes mclk from the bench; phases of 4 mclk.
`timescale 1ns/1ps
`default_nettype none
module drl_master (
  input wire logic mclk,
  output logic ser_clk,
  output logic ser_din,
  output logic ser_enb_n
);
  // Idle: clock still, enable high
  initial begin
    ser_clk = 1'b0;
    ser_din = 1'b0;
    ser_enb_n = 1'b1;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // One frame of n clocks, MSB first
  task automatic frame(input int n, input logic [47:0] d);
    ser_enb_n <= 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      wt(4);
      ser_din <= d[i];
      wt(4);
      ser_clk <= 1'b1;
      wt(4);
      ser_clk <= 1'b0;
    end
    wt(4);
    ser_enb_n <= 1'b1;
    ser_din <= ~ser_din; // Released line shows no stale bit
    wt(12);
  endtask
endmodule
`default_nettype wire

// >>> sim/drl_monitor.sv
// Port checker for the divide-ratio loader.
// Assumes it is bound to drl_loader, one clock mclk.
`timescale 1ns/1ps
`default_nettype none
module drl_monitor (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic ser_enb_n,
  input wire logic ser_dout,
  input wire drl_pkg::drl_ratio_s ratio,
  input wire logic ratio_load,
  input wire logic [drl_pkg::REF_CFG_W-1:0] ref_cfg,
  input wire logic [drl_pkg::CTRL_W-1:0] ctrl_reg
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  // ************************************************************
  // Commit order and isolation
  // ************************************************************
  a_ratio_on_load: assert property (!$stable(ratio) |-> ratio_load)
    else $error("ratio moved without load");
  a_load_one_cycle: assert property (ratio_load |=> !ratio_load)
    else $error("load pulse too long");
  a_load_after_frame: assert property (ratio_load |-> ser_enb_n && $past(ser_enb_n, 3))
    else $error("load inside frame");
  a_swl_keeps_ctrl: assert property (ratio_load |-> $stable(ctrl_reg) && $stable(ref_cfg))
    else $error("swallow write hit ctrl");
  a_cfg_keeps_ratio: assert property (!$stable(ref_cfg) |-> !ratio_load && $stable(ratio) && $stable(ctrl_reg))
    else $error("reference write moved ratio");
  a_cfg_after_frame: assert property (!$stable(ref_cfg) |-> ser_enb_n && $past(ser_enb_n, 3))
    else $error("cfg changed in frame");
  a_ctrl_alone: assert property (!$stable(ctrl_reg) |-> ser_enb_n && $stable(ref_cfg) && $stable(ratio))
    else $error("ctrl write moved others");
  a_quiet_in_frame: assert property (!ser_enb_n [*8] |-> $stable(ratio) && $stable(ref_cfg) && $stable(ctrl_reg))
    else $error("output moved in frame");
  a_dout_in_frame: assert property (!$stable(ser_dout) |-> !ser_enb_n)
    else $error("cascade bit moved outside frame");
endmodule
bind drl_loader drl_monitor u_drl_monitor (.mclk, .arst_n, .ser_enb_n, .ser_dout, .ratio, .ratio_load, .ref_cfg,
  .ctrl_reg);
`default_nettype wire
